/* File: src/swb_pkg.sv */
// Purpose: shared constants and types for the store write buffer
// Assumes: one 100 MHz clock, asynchronous active-high reset
// Notes: register map for the AXI4-Lite slave is kept here as well
package swb_pkg;
    localparam int NUM_ENT = 6;
    localparam int PTR_W = 3;
    localparam int ADDR_W = 40;
    localparam int BLK_LSB = 5;
    localparam int TAG_W = 35;
    localparam int UNIT_N = 8;
    localparam int UNIT_W = 32;
    localparam int LINE_W = 256;
    localparam logic [PTR_W:0] ENT_CNT = 4'h6;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [PTR_W:0] PEND_TRIG = 4'h2;
    localparam logic [1:0] OUT_MAX = 2'h2;
    localparam int TIMER_W = 6;
    localparam logic [TIMER_W-1:0] TIMER_LAST = 6'h3f;
    localparam int AXI_AW = 4;
    localparam logic [AXI_AW-1:0] OFF_CTRL = 4'h0;
    localparam logic [AXI_AW-1:0] OFF_STAT = 4'h4;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int CTRL_TIMER_BIT = 0;
    localparam int CTRL_FLUSH_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [63:0] data;
        logic [1:0] unitMask;
        logic noMerge;
        logic nonCache;
    } swb_store_t;

    typedef struct packed {
        logic [PTR_W-1:0] entry;
        logic [TAG_W-1:0] blkAddr;
        logic [LINE_W-1:0] data;
        logic [UNIT_N-1:0] unitMask;
        logic nonCache;
    } swb_req_t;

    typedef struct packed {
        logic nextWb;
        logic flush;
        logic [1:0] outCnt;
        logic [PTR_W:0] pendCnt;
        logic [NUM_ENT-1:0] valid;
    } swb_status_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } swb_rdst_t;
endpackage : swb_pkg

/* File: src/swb_axil.sv */
// Purpose: AXI4-Lite slave holding control and status words
// Assumes: one write and one read at a time
// Notes: unmapped offsets answer SLVERR, reads return zero there
`timescale 1ns/1ps
`default_nettype none
module swb_axil
    import swb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire swb_status_t status,
    output logic [1:0] ctrl
);
    logic awHeld_reg, wHeld_reg, wrDo;
    logic [AXI_AW-1:0] wAddr_reg;
    logic [7:0] wByte_reg;
    logic wStrb_reg;
    swb_rdst_t rdState_reg;

    assign wrDo = awHeld_reg && wHeld_reg && !s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wAddr_reg <= '0;
            wByte_reg <= '0;
            wStrb_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wAddr_reg <= s_axi_awaddr;
                awHeld_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte_reg <= s_axi_wdata[7:0];
                wStrb_reg <= s_axi_wstrb[0];
                wHeld_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wrDo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wAddr_reg == OFF_CTRL || wAddr_reg == OFF_STAT) ?
                    RESP_OKAY : RESP_SLVERR;
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // status word is read-only; writes to it are accepted and dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RST;
        end else if (wrDo && wAddr_reg == OFF_CTRL && wStrb_reg) begin
            ctrl <= wByte_reg[1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdState_reg <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            case (rdState_reg)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        rdState_reg <= RD_DATA;
                        s_axi_rresp <= RESP_OKAY;
                        if (s_axi_araddr == OFF_CTRL) begin
                            s_axi_rdata <= {30'h0, ctrl};
                        end else if (s_axi_araddr == OFF_STAT) begin
                            s_axi_rdata <= {18'h0, status};
                        end else begin
                            s_axi_rdata <= '0;
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdState_reg <= RD_IDLE;
                    end
                end
                default: begin
                    rdState_reg <= RD_IDLE;
                end
            endcase
        end
    end
endmodule : swb_axil
`default_nettype wire

/* File: src/swb_top.sv */
// Purpose: store write buffer between pipeline and cache control unit
// Assumes: partner completes and retries only entries it was given
// Notes: request holds until reqReady; no new request in its cycle
`timescale 1ns/1ps
`default_nettype none
module swb_top
    import swb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stValid,
    input wire swb_store_t stIn,
    output logic stReady,
    input wire logic wbarPulse,
    input wire logic mbActive,
    input wire logic llPulse,
    input wire logic ldValid,
    input wire logic [ADDR_W-1:0] ldAddr,
    output logic ldConflict,
    output logic [NUM_ENT-1:0] ldHitEntries,
    output logic ldBlock,
    output logic reqValid,
    output var swb_req_t req,
    input wire logic reqReady,
    input wire logic doneValid,
    input wire logic [PTR_W-1:0] doneEntry,
    input wire logic retryValid,
    input wire logic [PTR_W-1:0] retryEntry,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    logic [NUM_ENT-1:0] valid_reg, noMerge_reg, wbFlag_reg, special_reg;
    logic [NUM_ENT-1:0] nonCache_reg, issued_reg, retry_reg, flush_reg;
    logic [NUM_ENT-1:0] confl_reg, conflNext;
    logic [TAG_W-1:0] tag_reg [NUM_ENT];
    logic [LINE_W-1:0] data_reg [NUM_ENT];
    logic [UNIT_N-1:0] mask_reg [NUM_ENT];
    logic [PTR_W-1:0] freeQ_reg [NUM_ENT];
    logic [PTR_W-1:0] pendQ_reg [NUM_ENT];
    logic [PTR_W-1:0] freeHead_reg, pendHead_reg;
    logic [PTR_W:0] freeCnt_reg, pendCnt_reg, freeCntNext;
    logic [1:0] outCnt_reg;
    logic [TIMER_W-1:0] timerCnt_reg;
    logic timerReq_reg, llReq_reg, nextWb_reg;
    logic stReady_reg, reqValid_reg, ldConflict_reg, ldBlock_reg;
    logic [NUM_ENT-1:0] ldHitEntries_reg;
    swb_req_t req_reg;
    swb_status_t status;
    logic [1:0] ctrl;
    logic [NUM_ENT-1:0] stHit, ldHit, canMerge, mergeVec;
    logic [PTR_W-1:0] pendHeadIdx, allocIdx, tgtIdx, issueIdx;
    logic [UNIT_N-1:0] unitBits;
    logic blockHead, urge, issueNew, issueRetry, accept, doMerge, alloc;
    logic timerTick, ldAnyHit;

    function automatic logic [PTR_W-1:0] swbWrap(
        input logic [PTR_W-1:0] base,
        input logic [PTR_W-1:0] off
    );
        logic [PTR_W:0] s;
        s = {1'b0, base} + {1'b0, off};
        if (s >= ENT_CNT) begin
            s = s - ENT_CNT;
        end
        return s[PTR_W-1:0];
    endfunction : swbWrap

    // block-granular compare, mask bits are ignored on purpose
    function automatic logic [NUM_ENT-1:0] swbMatch(input logic [TAG_W-1:0] t);
        logic [NUM_ENT-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_ENT; i++) begin
            m[i] = valid_reg[i] && tag_reg[i] == t;
        end
        return m;
    endfunction : swbMatch

    function automatic logic [PTR_W-1:0] swbFirst(input logic [NUM_ENT-1:0] v);
        logic [PTR_W-1:0] k;
        k = '0;
        for (int i = NUM_ENT - 1; i >= 0; i--) begin
            if (v[i]) begin
                k = PTR_W'(i);
            end
        end
        return k;
    endfunction : swbFirst

    assign stReady = stReady_reg;
    assign reqValid = reqValid_reg;
    assign req = req_reg;
    assign ldConflict = ldConflict_reg;
    assign ldHitEntries = ldHitEntries_reg;
    assign ldBlock = ldBlock_reg;
    assign timerTick = timerCnt_reg == TIMER_LAST;

    always_comb begin
        stHit = swbMatch(stIn.addr[ADDR_W-1:BLK_LSB]);
        ldHit = swbMatch(ldAddr[ADDR_W-1:BLK_LSB]);
        ldAnyHit = ldValid && |ldHit;
        pendHeadIdx = pendQ_reg[pendHead_reg];
        allocIdx = freeQ_reg[freeHead_reg];
        // barrier head waits for all earlier writes to finish
        blockHead = (wbFlag_reg[pendHeadIdx] && outCnt_reg != 2'h0)
            || (nonCache_reg[pendHeadIdx] && |(issued_reg & nonCache_reg));
        urge = pendCnt_reg >= PEND_TRIG
            || timerReq_reg
            || llReq_reg
            || |(valid_reg & (special_reg | wbFlag_reg)) || mbActive
            || |flush_reg
            || ctrl[CTRL_FLUSH_BIT];
        issueRetry = !reqValid_reg && |retry_reg;
        issueNew = !reqValid_reg && !(|retry_reg) && pendCnt_reg != '0
            && urge && !blockHead && outCnt_reg != OUT_MAX;
        canMerge = valid_reg & ~noMerge_reg & ~issued_reg & ~special_reg;
        if (issueNew) begin
            canMerge[pendHeadIdx] = 1'b0;
        end
        mergeVec = stIn.noMerge ? '0 : (stHit & canMerge);
        accept = stValid && stReady_reg;
        doMerge = accept && |mergeVec;
        alloc = accept && !(|mergeVec);
        tgtIdx = doMerge ? swbFirst(mergeVec) : allocIdx;
        issueIdx = issueRetry ? swbFirst(retry_reg) : pendHeadIdx;
        unitBits = UNIT_N'(stIn.unitMask) << {stIn.addr[4:3], 1'b0};
        freeCntNext = freeCnt_reg + {3'h0, doneValid} - {3'h0, alloc};
        conflNext = confl_reg | (ldValid ? ldHit : '0);
        if (doneValid) begin
            conflNext[doneEntry] = 1'b0;
        end
    end

    // free queue refills in completion order
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            freeHead_reg <= '0;
            freeCnt_reg <= ENT_CNT;
            for (int i = 0; i < NUM_ENT; i++) begin
                freeQ_reg[i] <= PTR_W'(i);
            end
        end else begin
            if (alloc) begin
                freeHead_reg <= swbWrap(freeHead_reg, PTR_ONE);
            end
            if (doneValid) begin
                freeQ_reg[swbWrap(freeHead_reg, freeCnt_reg[PTR_W-1:0])] <= doneEntry;
            end
            freeCnt_reg <= freeCntNext;
        end
    end

    // pending queue keeps allocation order
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pendHead_reg <= '0;
            pendCnt_reg <= '0;
            for (int i = 0; i < NUM_ENT; i++) begin
                pendQ_reg[i] <= '0;
            end
        end else begin
            if (alloc) begin
                pendQ_reg[swbWrap(pendHead_reg, pendCnt_reg[PTR_W-1:0])] <= allocIdx;
            end
            if (issueNew) begin
                pendHead_reg <= swbWrap(pendHead_reg, PTR_ONE);
            end
            pendCnt_reg <= pendCnt_reg + {3'h0, alloc} - {3'h0, issueNew};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            valid_reg <= '0;
            noMerge_reg <= '0;
            wbFlag_reg <= '0;
            special_reg <= '0;
            nonCache_reg <= '0;
            issued_reg <= '0;
            retry_reg <= '0;
            flush_reg <= '0;
            confl_reg <= '0;
        end else begin
            confl_reg <= conflNext;
            for (int i = 0; i < NUM_ENT; i++) begin
                if (alloc && allocIdx == PTR_W'(i)) begin
                    valid_reg[i] <= 1'b1;
                    noMerge_reg[i] <= stIn.noMerge;
                    special_reg[i] <= stIn.noMerge;
                    nonCache_reg[i] <= stIn.nonCache;
                    wbFlag_reg[i] <= nextWb_reg || |stHit;
                end else begin
                    if (wbarPulse && valid_reg[i]) begin
                        noMerge_reg[i] <= 1'b1;
                    end
                    if (ldAnyHit && ldHit[i]) begin
                        noMerge_reg[i] <= 1'b1;
                    end
                    if (issueNew && pendHeadIdx == PTR_W'(i)) begin
                        noMerge_reg[i] <= 1'b1;
                        issued_reg[i] <= 1'b1;
                    end
                end
                if (issueRetry && issueIdx == PTR_W'(i)) begin
                    retry_reg[i] <= 1'b0;
                end
                if (retryValid && retryEntry == PTR_W'(i)) begin
                    retry_reg[i] <= 1'b1;
                end
                if (ldAnyHit && valid_reg[i]) begin
                    flush_reg[i] <= 1'b1;
                end
                // an entry that completes needs no drain or retry
                if (doneValid && doneEntry == PTR_W'(i)) begin
                    valid_reg[i] <= 1'b0;
                    issued_reg[i] <= 1'b0;
                    wbFlag_reg[i] <= 1'b0;
                    flush_reg[i] <= 1'b0;
                    retry_reg[i] <= 1'b0;
                end
            end
        end
    end

    // payload storage needs no reset, mask is rebuilt on allocation
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_ENT; i++) begin
            if ((alloc || doMerge) && tgtIdx == PTR_W'(i)) begin
                tag_reg[i] <= stIn.addr[ADDR_W-1:BLK_LSB];
                mask_reg[i] <= alloc ? unitBits : (mask_reg[i] | unitBits);
                for (int u = 0; u < UNIT_N; u++) begin
                    if (unitBits[u]) begin
                        data_reg[i][u*UNIT_W +: UNIT_W] <= stIn.data[(u%2)*UNIT_W +: UNIT_W];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            outCnt_reg <= '0;
        end else begin
            outCnt_reg <= outCnt_reg + {1'b0, issueNew} - {1'b0, doneValid};
        end
    end

    // requests set their flag even in the cycle an issue clears it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerCnt_reg <= '0;
            timerReq_reg <= 1'b0;
            llReq_reg <= 1'b0;
            nextWb_reg <= 1'b0;
        end else begin
            if (ctrl[CTRL_TIMER_BIT]) begin
                timerCnt_reg <= timerCnt_reg + 6'h01;
            end
            timerReq_reg <= (timerTick && ctrl[CTRL_TIMER_BIT])
                || (timerReq_reg && !issueNew);
            llReq_reg <= llPulse || (llReq_reg && !issueNew);
            nextWb_reg <= wbarPulse || (nextWb_reg && !alloc);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stReady_reg <= 1'b0;
            ldConflict_reg <= 1'b0;
            ldHitEntries_reg <= '0;
            ldBlock_reg <= 1'b0;
        end else begin
            // conservative: merges also wait while no entry is free
            stReady_reg <= freeCntNext != '0;
            ldConflict_reg <= ldAnyHit;
            ldHitEntries_reg <= ldValid ? ldHit : '0;
            ldBlock_reg <= |conflNext;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reqValid_reg <= 1'b0;
            req_reg <= '0;
        end else if (issueNew || issueRetry) begin
            reqValid_reg <= 1'b1;
            req_reg.entry <= issueIdx;
            req_reg.blkAddr <= tag_reg[issueIdx];
            req_reg.data <= data_reg[issueIdx];
            req_reg.unitMask <= mask_reg[issueIdx];
            req_reg.nonCache <= nonCache_reg[issueIdx];
        end else if (reqReady) begin
            reqValid_reg <= 1'b0;
        end
    end

    assign status = '{nextWb: nextWb_reg, flush: |flush_reg, outCnt: outCnt_reg,
        pendCnt: pendCnt_reg, valid: valid_reg};

    swb_axil u_axil (
        .ref_clk(ref_clk),
        .rst(rst),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .status(status),
        .ctrl(ctrl)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence sWbarSeen;
        wbarPulse && !alloc;
    endsequence

    sequence sLoadHit;
        ldValid && |ldHit;
    endsequence

    AST_WB_HOLD: assert property (issueNew && wbFlag_reg[pendHeadIdx] |-> outCnt_reg == 2'h0)
        else $error("barrier entry issued with writes outstanding");
    AST_OUT_MAX: assert property (outCnt_reg == OUT_MAX |=> !$rose(reqValid_reg) || $past(issueRetry))
        else $error("third request issued");
    AST_TWO_PEND: assert property (pendCnt_reg >= PEND_TRIG && !reqValid_reg && retry_reg == '0
        && outCnt_reg == 2'h0 && !blockHead |=> reqValid_reg && pendCnt_reg == $past(pendCnt_reg) - 4'h1
        + {3'h0, $past(alloc)})
        else $error("head not issued with two pending");
    AST_STALL: assert property (freeCnt_reg == '0 && !doneValid |=> !stReady_reg)
        else $error("store taken with no free entry");
    AST_WBAR_NM: assert property (sWbarSeen |=> (noMerge_reg & $past(valid_reg)) == $past(valid_reg))
        else $error("valid entry still open after write_barrier");
    AST_WBAR_NEXT: assert property (sWbarSeen ##1 (alloc && !wbarPulse) |=> wbFlag_reg[$past(allocIdx)])
        else $error("next entry lacks barrier flag");
    AST_LD_CONFL: assert property (sLoadHit |=> ldConflict_reg && ldBlock_reg && flush_reg != '0)
        else $error("load hit did not raise conflict");
    AST_DONE_FREE: assert property (doneValid |=> !valid_reg[$past(doneEntry)]
        && freeCnt_reg == $past(freeCnt_reg) + 4'h1 - {3'h0, $past(alloc)})
        else $error("completed entry not freed");
    AST_TIMER: assert property (timerTick && ctrl[CTRL_TIMER_BIT] |=> timerReq_reg)
        else $error("timer tick lost");
    AST_MERGE: assert property (doMerge && !doneValid |=> $stable(freeCnt_reg))
        else $error("merging store consumed an entry");
endmodule : swb_top
`default_nettype wire

/* File: testbench/swb_cbu_model.sv */
// Purpose: cache control unit stand-in
// Assumes: requests held until taken
// Notes: ready stalls every other cycle; newest finishes first
// Notes: first finish slot sends a retransmit request instead
`timescale 1ns/1ps
`default_nettype none
module swb_cbu_model
    import swb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire swb_req_t req,
    output logic reqReady,
    output logic doneValid,
    output logic [PTR_W-1:0] doneEntry,
    output logic retryValid,
    output logic [PTR_W-1:0] retryEntry
);
    logic [PTR_W-1:0] held[$];
    logic [3:0] age;
    logic retried;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reqReady <= 1'b0;
            doneValid <= 1'b0;
            doneEntry <= 3'h0;
            age <= 4'h0;
            retryValid <= 1'b0;
            retryEntry <= 3'h0;
            retried <= 1'b0;
        end else begin
            age <= age + 4'h1;
            reqReady <= age[0];
            doneValid <= 1'b0;
            retryValid <= 1'b0;
            if (reqValid && reqReady) held.push_back(req.entry);
            if (age == 4'hf && held.size() != 0) begin
                if (!retried) begin
                    retryEntry <= held.pop_back();
                    retryValid <= 1'b1;
                    retried <= 1'b1;
                end else begin
                    doneEntry <= held.pop_back();
                    doneValid <= 1'b1;
                end
            end
        end
    end
endmodule : swb_cbu_model
`default_nettype wire

/* File: testbench/store_write_buffer_tb.sv */
// Purpose: bench for store write buffer
// Assumes: partner model completes requests
// Notes: expected requests queued by the driver
`timescale 1ns/1ps
`default_nettype none
module store_write_buffer_tb
    import swb_pkg::*;
;
    logic ref_clk = 0, rst = 1, stValid = 0, ldValid = 0;
    logic wbarPulse = 0, mbActive = 0, llPulse = 0, retryValid;
    logic [2:0] retryEntry, doneEntry;
    logic [39:0] ldAddr = 0, a, b;
    logic [63:0] d;
    logic [7:0] resend = '0;
    swb_store_t stIn = '0;
    swb_req_t req;
    logic stReady, ldConflict, ldBlock, reqValid, reqReady, doneValid;
    logic [5:0] ldHitEntries;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
    logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, lfsrState = 71403;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [74:0] expQ[$], seen[8];
    wire [31:0] reqWord = req.unitMask[0] ? req.data[31:0] : req.data[63:32];
    int n_fail = 0, cmp_count = 0, i;
    swb_top dut (.*);
    swb_cbu_model cbu (.*);
    initial forever #5 ref_clk = ~ref_clk;
    function logic [31:0] lfsr();
        lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
        return lfsrState;
    endfunction : lfsr
    task end_sim();
        $display("comparisons %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task chk(input string s, input logic [79:0] e, input logic [79:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // bounded wait; a lapse ends the run
    task waitOn(input int k);
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (!((k == 0 ? stReady : k == 1 ? s_axi_arready : k == 2 ? s_axi_rvalid
            : k == 3 ? s_axi_awready & s_axi_wready : k == 4 ? s_axi_bvalid
            : expQ.size() == 0) === 1'b1) && i < 999);
        if (i >= 999) begin
            chk("timeout", 0, 1);
            end_sim();
        end
    endtask : waitOn
    task st(input logic [39:0] ad, input logic [1:0] m, input logic [63:0] dt);
        stValid <= 1'b1;
        stIn <= '{ad, dt, m, 1'b0, 1'b0};
        waitOn(0);
    endtask : st
    task rd(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] r);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= ad;
        waitOn(1);
        s_axi_arvalid <= 1'b0;
        waitOn(2);
        chk("rdata", d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask : rd
    task wr(input logic [3:0] ad, input logic [31:0] d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        waitOn(3);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        waitOn(4);
        chk("bresp", RESP_OKAY, s_axi_bresp);
    endtask : wr
    // a retransmit must repeat what that entry carried the first time
    always @(posedge ref_clk) begin
        if (retryValid) resend[retryEntry] <= 1'b1;
        if (reqValid && reqReady) begin
            if (resend[req.entry]) begin
                resend[req.entry] <= 1'b0;
                chk("resend", seen[req.entry], {req.blkAddr, req.unitMask, reqWord});
            end else if (expQ.size() == 0) begin
                chk("extra req", 0, 1);
            end else begin
                seen[req.entry] <= {req.blkAddr, req.unitMask, reqWord};
                chk("req", expQ.pop_front(), {req.blkAddr, req.unitMask, reqWord});
            end
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFF_STAT, 32'h0, RESP_OKAY);
        rd(OFF_CTRL, 32'h1, RESP_OKAY);
        rd(4'h8, 32'h0, RESP_SLVERR);
        a = {lfsr(), 8'h00};
        d = {lfsr(), lfsr()};
        expQ.push_back({a[39:5], 8'h0d, d[31:0]});
        st(a, 2'h1, d);
        st(a | 40'h8, 2'h3, {lfsr(), lfsr()});
        stValid <= 1'b0;
        wbarPulse <= 1'b1;
        @(posedge ref_clk);
        wbarPulse <= 1'b0;
        b = {lfsr(), 8'h00};
        for (int k = 1; k < 4; k++) begin
            d = {lfsr(), lfsr()};
            expQ.push_back({b[39:5] + 35'(k), 8'h02, d[63:32]});
            st(b + 40'(k * 32), 2'h2, d);
        end
        stValid <= 1'b0;
        ldValid <= 1'b1;
        ldAddr <= b + 40'h64;
        @(posedge ref_clk);
        ldValid <= 1'b0;
        @(posedge ref_clk);
        chk("ldConflict", 1, ldConflict);
        chk("ldBlock", 1, ldBlock);
        chk("ldHitEntries", 1, $onehot(ldHitEntries));
        wr(OFF_CTRL, 32'h3);
        rd(OFF_CTRL, 32'h3, RESP_OKAY);
        waitOn(5);
        // run past one timer period so the periodic request fires
        repeat (70) @(posedge ref_clk);
        end_sim();
    end
endmodule : store_write_buffer_tb
`default_nettype wire
